//--- hw/tpc_pkg.sv
// constants and types of the timing packet classifier
package tpc_pkg;
  localparam int HDR_LEN = 64;
  localparam int POS_W = 6;
  localparam int CNT_W = 7;
  localparam int KEY_LEN = 12;
  localparam int N_PROTO = 4;
  localparam int PROTO_W = 2;
  localparam int N_MATCH = 4;
  localparam int N_RULES = 8;
  localparam int RULE_W = 3;
  localparam int CONN_W = 4;
  localparam int ROUTE_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_W = 8;
  localparam int WORD_W = BYTE_W + 1;
  localparam int MAC_W = 48;
  localparam int DST_OFF = 0;
  localparam int SRC_OFF = 6;
  localparam int TYPE_OFF = 12;
  localparam int LLC_OFF = 14;
  localparam int SNAP_SHIFT = 8;
  localparam logic [CNT_W-1:0] HDR_CNT = 7'h40;
  localparam logic [CNT_W-1:0] MIN_FRM = 7'h0E;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [POS_W-1:0] POS_ONE = 6'h01;
  localparam logic [POS_W-1:0] POS_TWO = 6'h02;
  localparam logic [15:0] LEN_TYPE_MAX = 16'h0600;
  localparam logic [7:0] SNAP_DSAP = 8'hAA;
  localparam logic [7:0] SNAP_SSAP = 8'hAA;
  localparam logic [7:0] SNAP_CTRL = 8'h03;
  localparam logic [MAC_W-1:0] BCAST_MAC = 48'hFFFFFFFFFFFF;
  localparam logic [ROUTE_W-1:0] ROUTE_LOOP = 2'h2;
  typedef logic [HDR_LEN-1:0][7:0] tpc_hdr_t;
  typedef logic [KEY_LEN-1:0][7:0] tpc_key_t;
  typedef enum logic [2:0] {
    S_CAPT = 3'b000,
    S_FILT = 3'b001,
    S_PROTO = 3'b010,
    S_RULE = 3'b011,
    S_OUT = 3'b100
  } tpc_state_e;
endpackage : tpc_pkg

//--- hw/tpc_stream_if.sv
// byte stream carrier between the fifo and the classifier
`timescale 1ns/1ps
interface tpc_stream_if #(parameter int W = 9) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : tpc_stream_if

//--- hw/tpc_fifo.sv
// synchronous flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module tpc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  tpc_stream_if.src outPort
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W:0] wrPtr_r;
  logic [PTR_W:0] rdPtr_r;
  logic full;
  logic empty;
  logic doWr;
  logic doRd;

  assign empty = wrPtr_r == rdPtr_r;
  assign full = (wrPtr_r[PTR_W] != rdPtr_r[PTR_W]) &&
                (wrPtr_r[PTR_W-1:0] == rdPtr_r[PTR_W-1:0]);
  assign inReady = !full;
  assign doWr = inValid && !full;
  assign doRd = outPort.ready && !empty;
  assign outPort.valid = !empty;
  assign outPort.data = mem_r[rdPtr_r[PTR_W-1:0]];

  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem_r[wrPtr_r[PTR_W-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_r <= '0;
    end else if (doWr) begin
      wrPtr_r <= wrPtr_r + (PTR_W+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdPtr_r <= '0;
    end else if (doRd) begin
      rdPtr_r <= rdPtr_r + (PTR_W+1)'(1);
    end
  end
endmodule : tpc_fifo

//--- hw/tpc_classifier.sv
// three-stage receive packet classifier for timing connections
// Overview of operation
// - stage one checks destination mac and ethertype, drops failures early
// - stage one rewrites length-type snap frames into ethernet ii form
// - frames passing stage one always go on to protocol matching
// - four protocol matchers compare fixed bytes at programmed positions
// - a frame matching no protocol is dropped in stage two
// - stage two packs twelve programmed header bytes into one key
// - stage three compares the key to rule references, drops on miss
// - a matching rule names the connection and route of the frame
// - sequence, timestamp and length fields are extracted and passed on
// - check bytes must equal the rule value before a frame is accepted
// - each stage has its own independent configuration inputs
// - loopback route carries a reply header addressed back to the sender
`timescale 1ns/1ps
module tpc_classifier (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  input wire logic rxValid,
  output logic rxReady,
  input wire logic [47:0] cfgDstMac,
  input wire logic cfgDstMacEn,
  input wire logic cfgBcastAccept,
  input wire logic cfgTypeEn,
  input wire logic [15:0] cfgType,
  input wire logic [3:0] cfgProtoEn,
  input wire logic [3:0][3:0] cfgMatchUse,
  input wire logic [3:0][3:0][5:0] cfgMatchPos,
  input wire logic [3:0][3:0][7:0] cfgMatchVal,
  input wire logic [3:0][11:0][5:0] cfgKeyPos,
  input wire logic [3:0][5:0] cfgSeqPos,
  input wire logic [3:0][5:0] cfgTsPos,
  input wire logic [3:0][5:0] cfgLenPos,
  input wire logic [3:0][5:0] cfgChkPos,
  input wire logic [7:0] cfgRuleEn,
  input wire logic [7:0][1:0] cfgRuleProto,
  input wire logic [7:0][95:0] cfgRuleKey,
  input wire logic [7:0][95:0] cfgRuleMask,
  input wire logic [7:0][15:0] cfgRuleChk,
  input wire logic [7:0][3:0] cfgRuleConn,
  input wire logic [7:0][1:0] cfgRuleRoute,
  output logic descValid,
  input wire logic descReady,
  output logic [3:0] descConn,
  output logic [1:0] descRoute,
  output logic [1:0] descProto,
  output logic [15:0] descSeq,
  output logic [31:0] descTs,
  output logic [15:0] descLen,
  output logic descLoop,
  output logic [47:0] descReplyDst,
  output logic [47:0] descReplySrc
);
  tpc_stream_if #(.W(tpc_pkg::WORD_W)) fifoOut ();

  tpc_pkg::tpc_state_e state_r;
  tpc_pkg::tpc_hdr_t hdr_r;
  tpc_pkg::tpc_hdr_t norm_r;
  tpc_pkg::tpc_hdr_t normHdr;
  logic [tpc_pkg::CNT_W-1:0] cnt_r;
  logic [tpc_pkg::CNT_W-1:0] frmLen_r;
  logic take;
  logic [7:0] inByte;
  logic inLast;
  logic [15:0] rawType;
  logic isLenType;
  logic isSnap;
  logic [47:0] dstMac;
  logic dstOk;
  logic typeOk;
  logic pass1;
  logic [3:0][3:0] matchOk;
  logic [3:0] protoHit;
  logic [3:0][11:0][7:0] protoKey;
  logic protoAny;
  logic [tpc_pkg::PROTO_W-1:0] protoSel;
  logic [tpc_pkg::PROTO_W-1:0] proto_r;
  tpc_pkg::tpc_key_t key_r;
  logic [15:0] seq_r;
  logic [31:0] ts_r;
  logic [15:0] len_r;
  logic [15:0] chk_r;
  logic [47:0] srcMac_r;
  logic [47:0] dstMac_r;
  logic [7:0] ruleHit;
  logic ruleAny;
  logic [tpc_pkg::RULE_W-1:0] ruleSel;
  logic chkOk;

  function automatic logic [7:0] getByte(input tpc_pkg::tpc_hdr_t h,
                                         input logic [5:0] p);
    getByte = h[p];
  endfunction : getByte

  function automatic logic [15:0] get16(input tpc_pkg::tpc_hdr_t h,
                                        input logic [5:0] p);
    get16 = {getByte(h, p), getByte(h, p + tpc_pkg::POS_ONE)};
  endfunction : get16

  function automatic logic [31:0] get32(input tpc_pkg::tpc_hdr_t h,
                                        input logic [5:0] p);
    get32 = {get16(h, p), get16(h, p + tpc_pkg::POS_TWO)};
  endfunction : get32

  function automatic logic [47:0] getMac(input tpc_pkg::tpc_hdr_t h,
                                         input logic [5:0] p);
    getMac = {get16(h, p), get32(h, p + tpc_pkg::POS_TWO)};
  endfunction : getMac

  // input buffering
  tpc_fifo #(
    .WIDTH(tpc_pkg::WORD_W),
    .DEPTH(tpc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inData({rxLast, rxData}),
    .inValid(rxValid),
    .inReady(rxReady),
    .outPort(fifoOut.src)
  );

  // drain only while capturing, so frames are handled one at a time
  assign fifoOut.ready = state_r == tpc_pkg::S_CAPT;
  assign take = fifoOut.valid && fifoOut.ready;
  assign inByte = fifoOut.data[7:0];
  assign inLast = fifoOut.data[tpc_pkg::BYTE_W];

  // header capture, zero filled past the frame end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hdr_r <= '0;
    end else if (take) begin
      if (cnt_r == '0) begin
        hdr_r <= '0;
      end
      if (cnt_r < tpc_pkg::HDR_CNT) begin
        hdr_r[cnt_r[5:0]] <= inByte;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (take) begin
      if (inLast) begin
        cnt_r <= '0;
      end else if (cnt_r < tpc_pkg::HDR_CNT) begin
        cnt_r <= cnt_r + tpc_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frmLen_r <= '0;
    end else if (take && inLast) begin
      frmLen_r <= (cnt_r < tpc_pkg::HDR_CNT) ?
                  cnt_r + tpc_pkg::CNT_ONE : cnt_r;
    end
  end

  // stage one: pre-filter and format rewrite
  assign rawType = get16(hdr_r, 6'(tpc_pkg::TYPE_OFF));
  assign isLenType = rawType < tpc_pkg::LEN_TYPE_MAX;
  assign isSnap = hdr_r[tpc_pkg::LLC_OFF] == tpc_pkg::SNAP_DSAP &&
                  hdr_r[tpc_pkg::LLC_OFF+1] == tpc_pkg::SNAP_SSAP &&
                  hdr_r[tpc_pkg::LLC_OFF+2] == tpc_pkg::SNAP_CTRL;

  for (genvar i = 0; i < tpc_pkg::HDR_LEN; i++) begin : g_norm
    if (i < tpc_pkg::TYPE_OFF) begin : g_keep
      assign normHdr[i] = hdr_r[i];
    end else if (i + tpc_pkg::SNAP_SHIFT < tpc_pkg::HDR_LEN) begin : g_shift
      assign normHdr[i] = isLenType ? hdr_r[i+tpc_pkg::SNAP_SHIFT] :
                          hdr_r[i];
    end else begin : g_tail
      assign normHdr[i] = isLenType ? 8'h00 : hdr_r[i];
    end
  end

  assign dstMac = getMac(hdr_r, 6'(tpc_pkg::DST_OFF));
  assign dstOk = !cfgDstMacEn || dstMac == cfgDstMac ||
                 (cfgBcastAccept && dstMac == tpc_pkg::BCAST_MAC);
  assign typeOk = !cfgTypeEn ||
                  get16(normHdr, 6'(tpc_pkg::TYPE_OFF)) == cfgType;
  assign pass1 = dstOk && typeOk && (!isLenType || isSnap) &&
                 frmLen_r >= tpc_pkg::MIN_FRM;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      norm_r <= '0;
    end else if (state_r == tpc_pkg::S_FILT) begin
      norm_r <= normHdr;
    end
  end

  // stage two: protocol matchers and key gather
  for (genvar p = 0; p < tpc_pkg::N_PROTO; p++) begin : g_proto
    for (genvar m = 0; m < tpc_pkg::N_MATCH; m++) begin : g_match
      assign matchOk[p][m] = !cfgMatchUse[p][m] ||
          getByte(norm_r, cfgMatchPos[p][m]) == cfgMatchVal[p][m];
    end
    assign protoHit[p] = cfgProtoEn[p] && (&matchOk[p]);
    for (genvar k = 0; k < tpc_pkg::KEY_LEN; k++) begin : g_key
      assign protoKey[p][k] = getByte(norm_r, cfgKeyPos[p][k]);
    end
  end

  // lowest numbered matching protocol wins
  always_comb begin
    protoSel = '0;
    for (int p = tpc_pkg::N_PROTO - 1; p >= 0; p--) begin
      if (protoHit[p]) begin
        protoSel = tpc_pkg::PROTO_W'(p);
      end
    end
  end
  assign protoAny = |protoHit;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      proto_r <= '0;
      key_r <= '0;
    end else if (state_r == tpc_pkg::S_PROTO) begin
      proto_r <= protoSel;
      key_r <= protoKey[protoSel];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_r <= '0;
      ts_r <= '0;
      len_r <= '0;
      chk_r <= '0;
    end else if (state_r == tpc_pkg::S_PROTO) begin
      seq_r <= get16(norm_r, cfgSeqPos[protoSel]);
      ts_r <= get32(norm_r, cfgTsPos[protoSel]);
      len_r <= get16(norm_r, cfgLenPos[protoSel]);
      chk_r <= get16(norm_r, cfgChkPos[protoSel]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      srcMac_r <= '0;
      dstMac_r <= '0;
    end else if (state_r == tpc_pkg::S_PROTO) begin
      srcMac_r <= getMac(norm_r, 6'(tpc_pkg::SRC_OFF));
      dstMac_r <= getMac(norm_r, 6'(tpc_pkg::DST_OFF));
    end
  end

  // stage three: connection rules
  for (genvar r = 0; r < tpc_pkg::N_RULES; r++) begin : g_rule
    assign ruleHit[r] = cfgRuleEn[r] && cfgRuleProto[r] == proto_r &&
        ((key_r ^ cfgRuleKey[r]) & cfgRuleMask[r]) == '0;
  end

  always_comb begin
    ruleSel = '0;
    for (int r = tpc_pkg::N_RULES - 1; r >= 0; r--) begin
      if (ruleHit[r]) begin
        ruleSel = tpc_pkg::RULE_W'(r);
      end
    end
  end
  assign ruleAny = |ruleHit;
  assign chkOk = chk_r == cfgRuleChk[ruleSel];

  // frame sequencing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= tpc_pkg::S_CAPT;
    end else begin
      case (state_r)
        tpc_pkg::S_CAPT: begin
          if (take && inLast) begin
            state_r <= tpc_pkg::S_FILT;
          end
        end
        tpc_pkg::S_FILT: begin
          state_r <= pass1 ? tpc_pkg::S_PROTO : tpc_pkg::S_CAPT;
        end
        tpc_pkg::S_PROTO: begin
          state_r <= protoAny ? tpc_pkg::S_RULE : tpc_pkg::S_CAPT;
        end
        tpc_pkg::S_RULE: begin
          state_r <= (ruleAny && chkOk) ? tpc_pkg::S_OUT :
                     tpc_pkg::S_CAPT;
        end
        tpc_pkg::S_OUT: begin
          if (descReady) begin
            state_r <= tpc_pkg::S_CAPT;
          end
        end
        default: begin
          state_r <= tpc_pkg::S_CAPT;
        end
      endcase
    end
  end

  // accepted frame descriptor
  assign descValid = state_r == tpc_pkg::S_OUT;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      descConn <= '0;
      descRoute <= '0;
      descProto <= '0;
      descLoop <= 1'b0;
    end else if (state_r == tpc_pkg::S_RULE) begin
      descConn <= cfgRuleConn[ruleSel];
      descRoute <= cfgRuleRoute[ruleSel];
      descProto <= proto_r;
      descLoop <= cfgRuleRoute[ruleSel] == tpc_pkg::ROUTE_LOOP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      descSeq <= '0;
      descTs <= '0;
      descLen <= '0;
    end else if (state_r == tpc_pkg::S_RULE) begin
      descSeq <= seq_r;
      descTs <= ts_r;
      descLen <= len_r;
    end
  end

  // reply header swaps the addresses for loopback
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      descReplyDst <= '0;
      descReplySrc <= '0;
    end else if (state_r == tpc_pkg::S_RULE) begin
      descReplyDst <= srcMac_r;
      descReplySrc <= dstMac_r;
    end
  end
endmodule : tpc_classifier

//--- testbench/tpc_classifier_monitor.sv
// port assertions for the packet classifier
`timescale 1ns/1ps
module tpc_classifier_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rxLast,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic [3:0] cfgProtoEn,
  input wire logic [7:0] cfgRuleEn,
  input wire logic [7:0][1:0] cfgRuleProto,
  input wire logic [7:0][3:0] cfgRuleConn,
  input wire logic [7:0][1:0] cfgRuleRoute,
  input wire logic descValid,
  input wire logic descReady,
  input wire logic [3:0] descConn,
  input wire logic [1:0] descRoute,
  input wire logic [1:0] descProto,
  input wire logic [31:0] descTs,
  input wire logic descLoop
);
  logic [15:0] frmIn_r;
  logic [15:0] descOut_r;
  logic ruleHit;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    if (rst) frmIn_r <= 16'h0000;
    else if (rxValid && rxReady && rxLast) frmIn_r <= frmIn_r + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) descOut_r <= 16'h0000;
    else if (descValid && descReady) descOut_r <= descOut_r + 16'h0001;
  end
  always_comb begin
    ruleHit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      if (cfgRuleEn[r] && cfgRuleConn[r] == descConn &&
          cfgRuleRoute[r] == descRoute && cfgRuleProto[r] == descProto) begin
        ruleHit = 1'b1;
      end
    end
  end
  property p_hold;
    descValid && !descReady |=> descValid && $stable(descConn);
  endproperty
  a_hold: assert property (p_hold)
    else $error("descriptor changed before taken");
  property p_ts;
    descValid && !descReady |=> $stable(descTs) && $stable(descProto);
  endproperty
  a_ts: assert property (p_ts)
    else $error("descriptor fields changed before taken");
  property p_loop;
    descValid |-> descLoop == (descRoute == tpc_pkg::ROUTE_LOOP);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop flag disagrees with route");
  property p_after_rst;
    $past(rst) |-> !descValid && rxReady;
  endproperty
  a_after_rst: assert property (p_after_rst)
    else $error("outputs busy after reset");
  property p_count;
    $rose(descValid) |-> frmIn_r > descOut_r;
  endproperty
  a_count: assert property (p_count)
    else $error("descriptor without a frame");
  property p_gap;
    descValid && descReady |=> !descValid [*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("descriptor too soon after previous");
  property p_proto;
    descValid |-> cfgProtoEn[descProto];
  endproperty
  a_proto: assert property (p_proto)
    else $error("descriptor names disabled protocol");
  property p_rule;
    descValid |-> ruleHit;
  endproperty
  a_rule: assert property (p_rule)
    else $error("descriptor matches no enabled rule");
endmodule : tpc_classifier_monitor
bind tpc_classifier tpc_classifier_monitor mon (.sys_clk, .rst, .rxLast,
  .rxValid, .rxReady, .cfgProtoEn, .cfgRuleEn, .cfgRuleProto, .cfgRuleConn,
  .cfgRuleRoute, .descValid, .descReady, .descConn, .descRoute, .descProto,
  .descTs, .descLoop);

//--- testbench/tpc_mac_model.sv
// frame source and descriptor sink at the far side
`timescale 1ns/1ps
module tpc_mac_model (
  input wire logic sys_clk,
  input wire logic rst,
  output logic [7:0] rxData,
  output logic rxLast,
  output logic rxValid,
  input wire logic rxReady,
  output logic descReady
);
  int seed = 15;
  logic busy = 1'b0;
  logic hung = 1'b0;
  initial begin
    rxData = 8'h00;
    rxLast = 1'b0;
    rxValid = 1'b0;
    descReady = 1'b0;
  end
  // idle lane never keeps its last byte
  always @(negedge sys_clk) begin
    if (!busy) rxData <= ~rxData;
  end
  always @(negedge sys_clk) begin
    descReady <= !rst && ($random(seed) % 3 != 0);
  end
  task automatic send(input logic [7:0] f [80], input int n);
    int w;
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      rxValid <= 1'b1;
      rxData <= f[i];
      rxLast <= (i == n - 1);
      w = 0;
      while (!rxReady && w < 2000) begin
        @(negedge sys_clk);
        w++;
      end
      if (w == 2000) hung = 1'b1;
    end
  endtask : send
  task automatic release_bus();
    @(negedge sys_clk);
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    busy = 1'b0;
  endtask : release_bus
endmodule : tpc_mac_model

//--- testbench/tpc_classifier_bench.sv
// self-checking bench for the packet classifier
`timescale 1ns/1ps
module tpc_classifier_bench;
  logic sys_clk, rst, rxReady, rxLast, rxValid, descReady, descValid;
  logic descLoop, cfgDstMacEn, cfgBcastAccept, cfgTypeEn;
  logic [7:0] rxData, cfgRuleEn;
  logic [47:0] cfgDstMac, descReplyDst, descReplySrc;
  logic [15:0] cfgType, descSeq, descLen;
  logic [3:0] cfgProtoEn, descConn;
  logic [3:0][3:0] cfgMatchUse;
  logic [3:0][3:0][5:0] cfgMatchPos;
  logic [3:0][3:0][7:0] cfgMatchVal;
  logic [3:0][11:0][5:0] cfgKeyPos;
  logic [3:0][5:0] cfgSeqPos, cfgTsPos, cfgLenPos, cfgChkPos;
  logic [7:0][1:0] cfgRuleProto, cfgRuleRoute;
  logic [7:0][95:0] cfgRuleKey, cfgRuleMask;
  logic [7:0][15:0] cfgRuleChk;
  logic [7:0][3:0] cfgRuleConn;
  logic [1:0] descRoute, descProto;
  logic [31:0] descTs;
  logic [169:0] snap;
  logic [168:0] expQ[$], gotQ[$];
  logic sawFull = 1'b0;
  int seed = 15;
  int failures = 0;
  int checks = 0;
  tpc_classifier dut (.sys_clk, .rst, .rxData, .rxLast, .rxValid, .rxReady,
    .cfgDstMac, .cfgDstMacEn, .cfgBcastAccept, .cfgTypeEn, .cfgType,
    .cfgProtoEn, .cfgMatchUse, .cfgMatchPos, .cfgMatchVal, .cfgKeyPos,
    .cfgSeqPos, .cfgTsPos, .cfgLenPos, .cfgChkPos, .cfgRuleEn, .cfgRuleProto,
    .cfgRuleKey, .cfgRuleMask, .cfgRuleChk, .cfgRuleConn, .cfgRuleRoute,
    .descValid, .descReady, .descConn, .descRoute, .descProto, .descSeq,
    .descTs, .descLen, .descLoop, .descReplyDst, .descReplySrc);
  tpc_mac_model mac (.sys_clk, .rst, .rxData, .rxLast, .rxValid, .rxReady,
    .descReady);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (rxValid && !rxReady) sawFull = 1'b1;
    snap = {descValid, descConn, descRoute, descProto, descSeq, descTs,
      descLen, descLoop, descReplyDst, descReplySrc};
    if (mac.hung) begin
      failures++;
      print_verdict();
    end
  end
  always @(posedge sys_clk) begin
    if (!rst && snap[169] && descReady) gotQ.push_back(snap[168:0]);
  end
  task automatic check(input string what, input logic [168:0] e,
      input logic [168:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  function automatic logic [168:0] want(input logic [7:0] h [64],
      input logic p);
    logic s;
    s = h[20][0];
    return {p ? 4'h5 : s ? 4'h9 : 4'h3, p ? 2'h3 : s ? 2'h1 : 2'h2,
      {1'b0, p}, h[32], h[33], h[34],
      h[35], h[36], h[37], h[38], h[39], !s && !p, h[6], h[7], h[8], h[9],
      h[10], h[11], h[0], h[1], h[2], h[3], h[4], h[5]};
  endfunction : want
  // kinds: 0 good, 1 dst, 2 type, 3 second protocol, 4 key, 5 check,
  // 6 broadcast, 7 length-type snap, 8 no protocol, 9 short,
  // 10 length-type without snap
  task automatic frame(input int kind);
    logic [7:0] h [64];
    logic [7:0] raw [80];
    int n;
    for (int i = 0; i < 64; i++) h[i] = 8'($random(seed));
    for (int i = 0; i < 6; i++) h[i] = cfgDstMac[47-8*i -: 8];
    for (int k = 1; k < 12; k++) h[20+k] = 8'(16 + k);
    {h[12], h[13], h[14], h[20]} = {16'h88F7, 8'h5A, 7'h00, h[20][0]};
    {h[40], h[41]} = 16'hC396;
    case (kind)
      1: h[3] = ~h[3];
      2: h[13] = ~h[13];
      3: h[14] = 8'h5B;
      8: h[14] = 8'h5C;
      4: h[25] = ~h[25];
      5: h[41] = ~h[41];
      6: for (int i = 0; i < 6; i++) h[i] = 8'hFF;
      default: ;
    endcase
    n = (kind == 7 || kind == 10) ? 78 : kind == 9 ? 13 : 70;
    for (int i = 0; i < 80; i++) raw[i] = i < 64 ? h[i] : 8'($random(seed));
    if (kind == 7 || kind == 10) begin
      for (int i = 12; i < 72; i++) raw[i+8] = i < 64 ? h[i] : 8'h00;
      {raw[12], raw[13], raw[14], raw[15], raw[16]} = 40'h0040AAAA03;
      {raw[17], raw[18], raw[19]} = 24'h000000;
      if (kind == 10) raw[14] = 8'h42;
    end
    if (kind == 0 || kind == 3 || kind == 7 || (kind == 6 &&
        (cfgBcastAccept || !cfgDstMacEn)) || (kind == 1 && !cfgDstMacEn) ||
        (kind == 2 && !cfgTypeEn)) expQ.push_back(want(h, kind == 3));
    mac.send(raw, n);
  endtask : frame
  task automatic settle();
    int w;
    w = 0;
    mac.release_bus();
    while (gotQ.size() < expQ.size() && w < 5000) begin
      @(negedge sys_clk);
      w++;
    end
    if (w == 5000) failures++;
    if (w == 5000) print_verdict();
    repeat (200) @(negedge sys_clk);
  endtask : settle
  initial begin
    rst = 1'b1;
    {cfgDstMac, cfgDstMacEn, cfgBcastAccept} = {48'h02A4C81E5B37, 2'h3};
    {cfgTypeEn, cfgType, cfgProtoEn} = {1'h1, 16'h88F7, 4'h3};
    {cfgMatchUse, cfgMatchPos, cfgMatchVal} = {16'h0011, 96'h0, 128'h0};
    cfgMatchPos[0][0] = 6'h0E;
    cfgMatchPos[1][0] = 6'h0E;
    cfgMatchVal[0][0] = 8'h5A;
    cfgMatchVal[1][0] = 8'h5B;
    {cfgSeqPos, cfgTsPos} = {{4{6'h20}}, {4{6'h22}}};
    {cfgLenPos, cfgChkPos} = {{4{6'h26}}, {4{6'h28}}};
    {cfgRuleEn, cfgRuleProto, cfgRuleRoute} = {8'h07, 16'h0010, 16'h0036};
    {cfgRuleConn, cfgRuleChk} = {32'h00000593, {8{16'hC396}}};
    {cfgRuleKey, cfgRuleMask} = {768'h0, {8{96'hFFFFFFFFFFFFFFFFFFFFFFFF}}};
    cfgRuleMask[2][7:0] = 8'h00;
    for (int k = 0; k < 12; k++) begin
      cfgKeyPos[0][k] = 6'(20 + k);
      cfgKeyPos[1][k] = 6'(20 + k);
      cfgKeyPos[2][k] = 6'h00;
      cfgKeyPos[3][k] = 6'h00;
      cfgRuleKey[0][8*k +: 8] = k == 0 ? 8'h00 : 8'(16 + k);
      cfgRuleKey[1][8*k +: 8] = k == 0 ? 8'h01 : 8'(16 + k);
      cfgRuleKey[2][8*k +: 8] = 8'(16 + k);
    end
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    for (int f = 0; f < 48; f++) begin
      frame(f < 11 ? f : ($random(seed) & 7));
    end
    settle();
    cfgBcastAccept = 1'b0;
    frame(6);
    frame(0);
    settle();
    {cfgDstMacEn, cfgTypeEn} = 2'h0;
    frame(1);
    frame(2);
    frame(9);
    settle();
    check("fifo full seen", 169'h1, 169'(sawFull));
    check("rx ready drained", 169'h1, 169'(rxReady));
    check("count", 169'(expQ.size()), 169'(gotQ.size()));
    for (int i = 0; i < expQ.size() && i < gotQ.size(); i++)
      check("descriptor", expQ[i], gotQ[i]);
    print_verdict();
  end
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
endmodule : tpc_classifier_bench
